// *** common/svpt_consts.svh ***
// Offsets, field positions, reset values and timing counts of the video port
`ifndef SVPT_CONSTS_SVH
`define SVPT_CONSTS_SVH
`define SVPT_OFS_OFFSET_C 8'h25
`define SVPT_OFS_BL_WEIGHT 8'h26
`define SVPT_OFS_THR_A_HI 8'h27
`define SVPT_OFS_THR_A_LO 8'h28
`define SVPT_OFS_THR_B_HI 8'h29
`define SVPT_OFS_THR_B_LO 8'h2A
`define SVPT_REG_RESET 8'h00
`define SVPT_LO_FIELD_HI 7
`define SVPT_LO_FIELD_LO 4
`define SVPT_PCLK_HALF 4'h5
`define SVPT_HS_LVL_INACT 12'h074
`define SVPT_HS_LVL_ACT 12'h298
`define SVPT_HS_PLS_INACT 12'h010
`define SVPT_HS_PLS_ACT 12'h2FC
`define SVPT_VS_LVL_INACT 24'h000074
`define SVPT_VS_PLS_LEN 24'h000010
`define SVPT_ROW_FIRST_PIX 8'h7C
`define SVPT_SYNC_LAT 8'h02
`define SVPT_ROW_PIXELS 12'h280
`define SVPT_TRIG_MIN 3'h2
`define SVPT_TRIG_HOLD 3'h4
`define SVPT_ROW_SPACING 12'h30C
`define SVPT_FRAME_DEADLINE 12'h060
`endif

// *** common/svpt_pkg.sv ***
// Types used by the sensor end of the video port and by the testbench
package svpt_pkg;
	typedef enum logic [1:0] {
		mode_master,
		mode_slave,
		mode_snapshot
	} svpt_mode_t;
	typedef enum logic [1:0] {
		snap_idle,
		snap_delay,
		snap_integ,
		snap_read
	} svpt_snap_t;
endpackage

// *** common/svpt_if.sv ***
// Pin-level link between the sensor and the image processor
`timescale 1ns/100ps
interface svpt_if;
	logic pclk;
	logic line_sync;
	logic frame_sync;
	logic pix_valid;
	logic [11:0] pix_data;
	logic ext_sync;
	logic row_trig;
	logic frame_trig;
	logic snap_trig;
	modport dev (
		output pclk, line_sync, frame_sync, pix_valid, pix_data, ext_sync,
		input row_trig, frame_trig, snap_trig
	);
	modport host (
		input pclk, line_sync, frame_sync, pix_valid, pix_data, ext_sync,
		output row_trig, frame_trig, snap_trig
	);
endinterface

// *** rtl/svpt_sensor.sv ***
// Sensor end: video timing for master, slave and snapshot modes, registers
// Behaviour
// - Master line sync inactive: 116-adjust level, 16 pulse
// - Master line sync active: 664-adjust level, 764 pulse
// - First pixel adjust plus one pclk after sync
// - Master frame sync inactive: 116 level, 16 pulse
// - Master frame sync active: frame length minus 116, or 16
// - Row trigger held at least two mclk
// - Slave first pixel exactly 124 mclk after trigger
// - Row triggers at least 780 mclk apart
// - Frame trigger within 96 mclk of last row
// - Frame trigger held at least two mclk
// - Snapshot trigger held at least two mclk
// - Snapshot runs delay, integration, readout in order
// - Eight-bit weight for black level exponential averaging
// - Threshold A joins high byte and low nibble
// - Threshold B joins high byte and low nibble
// - Offset voltage code taken from offset register C
`timescale 1ns/100ps
`include "svpt_consts.svh"
module svpt_sensor (
	input wire logic clock,
	input wire logic rstn,
	svpt_if.dev vid,
	input wire svpt_pkg::svpt_mode_t mode,
	input wire logic level_mode,
	input wire logic [7:0] line_sync_lead_adjust,
	input wire logic [11:0] frame_length_lines,
	input wire logic [11:0] pix_in,
	input wire logic pix_in_black,
	input wire logic reg_we,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic [7:0] offset_voltage_code,
	output logic [11:0] defect_threshold_a,
	output logic [11:0] defect_threshold_b,
	output logic [11:0] black_level,
	output logic snap_busy
);
	logic [7:0] ofs_c_r, weight_r, thr_a_hi_r, thr_b_hi_r;
	logic [3:0] thr_a_lo_r, thr_b_lo_r;
	logic [3:0] div_r;
	logic pclk_r, fall_tick;
	logic [2:0] row_s_r, frm_s_r;
	logic [3:0] snap_s_r;
	logic row_edge, snap_edge;
	logic run, h_act_r, h_act_nxt, v_act_r, v_act_nxt;
	logic [11:0] h_cnt_r, h_cnt_nxt, h_len;
	logic [23:0] v_cnt_r, v_cnt_nxt, v_len, frame_pclks;
	logic [7:0] lat_r;
	logic lat_run_r;
	logic [11:0] row_cnt_r;
	svpt_pkg::svpt_snap_t snap_r;
	logic [23:0] snap_cnt_r;
	logic line_sync_r, frame_sync_r, pix_valid_r, ext_sync_r;
	logic [11:0] pix_data_r, black_r;
	logic [19:0] bl_diff;

	function automatic logic [11:0] line_pclks(input logic lvl,
		input logic [7:0] adj);
		if (lvl)
			line_pclks = `SVPT_HS_LVL_INACT + `SVPT_HS_LVL_ACT
				- {3'h0, adj, 1'b0};
		else
			line_pclks = `SVPT_HS_PLS_INACT + `SVPT_HS_PLS_ACT;
	endfunction

	function automatic logic [11:0] join_thr(input logic [7:0] hi,
		input logic [3:0] lo);
		join_thr = {hi, lo};
	endfunction

	// Register writes; low nibble of low threshold bytes not stored
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ofs_c_r <= `SVPT_REG_RESET;
			weight_r <= `SVPT_REG_RESET;
			thr_a_hi_r <= `SVPT_REG_RESET;
			thr_a_lo_r <= 4'h0;
			thr_b_hi_r <= `SVPT_REG_RESET;
			thr_b_lo_r <= 4'h0;
		end else if (reg_we) begin
			case (reg_addr)
				`SVPT_OFS_OFFSET_C: ofs_c_r <= reg_wdata;
				`SVPT_OFS_BL_WEIGHT: weight_r <= reg_wdata;
				`SVPT_OFS_THR_A_HI: thr_a_hi_r <= reg_wdata;
				`SVPT_OFS_THR_A_LO: thr_a_lo_r <= reg_wdata[`SVPT_LO_FIELD_HI:`SVPT_LO_FIELD_LO];
				`SVPT_OFS_THR_B_HI: thr_b_hi_r <= reg_wdata;
				`SVPT_OFS_THR_B_LO: thr_b_lo_r <= reg_wdata[`SVPT_LO_FIELD_HI:`SVPT_LO_FIELD_LO];
				default: ;
			endcase
		end
	end

	// Readback; unmapped addresses read zero
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else begin
			case (reg_addr)
				`SVPT_OFS_OFFSET_C: reg_rdata <= ofs_c_r;
				`SVPT_OFS_BL_WEIGHT: reg_rdata <= weight_r;
				`SVPT_OFS_THR_A_HI: reg_rdata <= thr_a_hi_r;
				`SVPT_OFS_THR_A_LO: reg_rdata <= {thr_a_lo_r, 4'h0};
				`SVPT_OFS_THR_B_HI: reg_rdata <= thr_b_hi_r;
				`SVPT_OFS_THR_B_LO: reg_rdata <= {thr_b_lo_r, 4'h0};
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			offset_voltage_code <= 8'h00;
			defect_threshold_a <= 12'h000;
			defect_threshold_b <= 12'h000;
		end else begin
			offset_voltage_code <= ofs_c_r;
			defect_threshold_a <= join_thr(thr_a_hi_r, thr_a_lo_r);
			defect_threshold_b <= join_thr(thr_b_hi_r, thr_b_lo_r);
		end
	end

	// Black level tracking: avg += (pix - avg) * weight / 256
	assign bl_diff = ({8'h00, pix_in} - {8'h00, black_r}) * {12'h000, weight_r};
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			black_r <= 12'h000;
		else if (pix_in_black)
			black_r <= black_r + bl_diff[19:8];
	end
	assign black_level = black_r;

	// Pixel clock divider
	assign fall_tick = pclk_r && (div_r == `SVPT_PCLK_HALF - 4'h1);
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			div_r <= 4'h0;
			pclk_r <= 1'b0;
		end else if (div_r == `SVPT_PCLK_HALF - 4'h1) begin
			div_r <= 4'h0;
			pclk_r <= !pclk_r;
		end else begin
			div_r <= div_r + 4'h1;
		end
	end

	// Trigger synchronisers; index 0 read only by index 1
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			row_s_r <= 3'h0;
			frm_s_r <= 3'h0;
			snap_s_r <= 4'h0;
		end else begin
			row_s_r <= {row_s_r[1:0], vid.row_trig};
			frm_s_r <= {frm_s_r[1:0], vid.frame_trig};
			snap_s_r <= {snap_s_r[2:0], vid.snap_trig};
		end
	end
	assign row_edge = row_s_r[1] && !row_s_r[2];
	// Snapshot taken only after two high samples
	assign snap_edge = snap_s_r[1] && snap_s_r[2] && !snap_s_r[3];

	// Master timing engine, stepped on pclk falling edge
	assign run = (mode == svpt_pkg::mode_master) || (snap_r == svpt_pkg::snap_read);
	// Operands widened first so the product is not cut to 12 bits
	assign frame_pclks = {12'h000, frame_length_lines} *
		{12'h000, line_pclks(level_mode, line_sync_lead_adjust)};
	always_comb begin
		if (h_act_r)
			h_len = level_mode ? `SVPT_HS_LVL_ACT - {4'h0, line_sync_lead_adjust}
				: `SVPT_HS_PLS_ACT;
		else
			h_len = level_mode ? `SVPT_HS_LVL_INACT - {4'h0, line_sync_lead_adjust}
				: `SVPT_HS_PLS_INACT;
		if (v_act_r)
			v_len = level_mode ? frame_pclks - `SVPT_VS_LVL_INACT
				: `SVPT_VS_PLS_LEN;
		else
			v_len = level_mode ? `SVPT_VS_LVL_INACT : `SVPT_VS_PLS_LEN;
		h_act_nxt = h_act_r;
		h_cnt_nxt = h_cnt_r + 12'h001;
		if (h_cnt_r >= h_len - 12'h001) begin
			h_act_nxt = !h_act_r;
			h_cnt_nxt = 12'h000;
		end
		v_act_nxt = v_act_r;
		v_cnt_nxt = v_cnt_r + 24'h000001;
		if (v_cnt_r >= v_len - 24'h000001) begin
			v_act_nxt = !v_act_r;
			v_cnt_nxt = 24'h000000;
		end
	end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			h_act_r <= 1'b0;
			h_cnt_r <= 12'h000;
			v_act_r <= 1'b0;
			v_cnt_r <= 24'h000000;
		end else if (!run) begin
			h_act_r <= 1'b0;
			h_cnt_r <= 12'h000;
			v_act_r <= 1'b0;
			v_cnt_r <= 24'h000000;
		end else if (fall_tick) begin
			h_act_r <= h_act_nxt;
			h_cnt_r <= h_cnt_nxt;
			v_act_r <= v_act_nxt;
			v_cnt_r <= v_cnt_nxt;
		end
	end

	// Slave row readout: latency counted from the pin edge
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			lat_r <= 8'h00;
			lat_run_r <= 1'b0;
			row_cnt_r <= 12'h000;
		end else if (mode != svpt_pkg::mode_slave) begin
			lat_run_r <= 1'b0;
			row_cnt_r <= 12'h000;
		end else if (row_edge) begin
			// Sync stages, load, count end and output flop all add a cycle
			lat_r <= `SVPT_ROW_FIRST_PIX - `SVPT_SYNC_LAT - 8'h03;
			lat_run_r <= 1'b1;
		end else if (lat_run_r) begin
			lat_r <= lat_r - 8'h01;
			if (lat_r == 8'h00) begin
				lat_run_r <= 1'b0;
				row_cnt_r <= `SVPT_ROW_PIXELS;
			end
		end else if (row_cnt_r != 12'h000) begin
			row_cnt_r <= row_cnt_r - 12'h001;
		end
	end

	// Snapshot sequence, each phase one frame length
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			snap_r <= svpt_pkg::snap_idle;
			snap_cnt_r <= 24'h000000;
		end else if (mode != svpt_pkg::mode_snapshot) begin
			snap_r <= svpt_pkg::snap_idle;
			snap_cnt_r <= 24'h000000;
		end else if (snap_r == svpt_pkg::snap_idle) begin
			snap_cnt_r <= 24'h000000;
			if (snap_edge)
				snap_r <= svpt_pkg::snap_delay;
		end else if (fall_tick) begin
			if (snap_cnt_r >= frame_pclks - 24'h000001) begin
				snap_cnt_r <= 24'h000000;
				case (snap_r)
					svpt_pkg::snap_delay: snap_r <= svpt_pkg::snap_integ;
					svpt_pkg::snap_integ: snap_r <= svpt_pkg::snap_read;
					svpt_pkg::snap_read: snap_r <= svpt_pkg::snap_idle;
					default: snap_r <= svpt_pkg::snap_idle;
				endcase
			end else begin
				snap_cnt_r <= snap_cnt_r + 24'h000001;
			end
		end
	end

	// Pin outputs
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			line_sync_r <= 1'b0;
			frame_sync_r <= 1'b0;
			pix_valid_r <= 1'b0;
			pix_data_r <= 12'h000;
			ext_sync_r <= 1'b0;
			snap_busy <= 1'b0;
		end else begin
			ext_sync_r <= snap_r == svpt_pkg::snap_integ;
			snap_busy <= snap_r != svpt_pkg::snap_idle;
			if (mode == svpt_pkg::mode_slave) begin
				line_sync_r <= row_cnt_r != 12'h000;
				pix_valid_r <= row_cnt_r != 12'h000;
				frame_sync_r <= frm_s_r[1];
				pix_data_r <= pix_in;
			end else if (!run) begin
				line_sync_r <= 1'b0;
				pix_valid_r <= 1'b0;
				frame_sync_r <= 1'b0;
			end else if (fall_tick) begin
				line_sync_r <= h_act_nxt;
				frame_sync_r <= v_act_nxt;
				pix_valid_r <= h_act_nxt &&
					h_cnt_nxt >= {4'h0, line_sync_lead_adjust} + 12'h001;
				pix_data_r <= pix_in;
			end
		end
	end

	assign vid.pclk = (mode == svpt_pkg::mode_slave) ? 1'b0 : pclk_r;
	assign vid.line_sync = line_sync_r;
	assign vid.frame_sync = frame_sync_r;
	assign vid.pix_valid = pix_valid_r;
	assign vid.pix_data = pix_data_r;
	assign vid.ext_sync = ext_sync_r;
endmodule

// *** rtl/svpt_processor.sv ***
// Image processor end: trigger generation and pixel capture
`timescale 1ns/100ps
`include "svpt_consts.svh"
module svpt_processor (
	input wire logic clock,
	input wire logic rstn,
	svpt_if.host vid,
	input wire logic slave_timing,
	input wire logic send_row,
	input wire logic send_frame,
	input wire logic send_snap,
	output logic row_ready,
	output logic frame_late,
	output logic [11:0] pix_word,
	output logic pix_strobe,
	output logic line_active,
	output logic frame_active,
	output logic shutter_sync
);
	logic [2:0] row_hold_r, frm_hold_r, snap_hold_r;
	logic [11:0] space_r, since_row_r;
	logic [2:0] pclk_s_r;
	logic [1:0] ls_s_r, fs_s_r, pv_s_r, es_s_r;
	logic [11:0] d1_r, d2_r;
	logic take;

	// Trigger pulse widths held beyond the two-cycle minimum
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			row_hold_r <= 3'h0;
			frm_hold_r <= 3'h0;
			snap_hold_r <= 3'h0;
		end else begin
			if (send_row && row_ready)
				row_hold_r <= `SVPT_TRIG_HOLD;
			else if (row_hold_r != 3'h0)
				row_hold_r <= row_hold_r - 3'h1;
			if (send_frame)
				frm_hold_r <= `SVPT_TRIG_HOLD;
			else if (frm_hold_r != 3'h0)
				frm_hold_r <= frm_hold_r - 3'h1;
			if (send_snap)
				snap_hold_r <= `SVPT_TRIG_HOLD;
			else if (snap_hold_r != 3'h0)
				snap_hold_r <= snap_hold_r - 3'h1;
		end
	end
	assign vid.row_trig = row_hold_r != 3'h0;
	assign vid.frame_trig = frm_hold_r != 3'h0;
	assign vid.snap_trig = snap_hold_r != 3'h0;

	// Row spacing and frame deadline tracking
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			space_r <= 12'h000;
			since_row_r <= 12'h000;
			row_ready <= 1'b0;
			frame_late <= 1'b0;
		end else begin
			row_ready <= space_r <= 12'h001 && !(send_row && row_ready);
			if (send_row && row_ready) begin
				space_r <= `SVPT_ROW_SPACING - 12'h001;
				since_row_r <= 12'h000;
			end else begin
				if (space_r != 12'h000)
					space_r <= space_r - 12'h001;
				if (since_row_r != 12'hFFF)
					since_row_r <= since_row_r + 12'h001;
			end
			if (send_frame)
				frame_late <= since_row_r > `SVPT_FRAME_DEADLINE;
		end
	end

	// Pin synchronisers
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pclk_s_r <= 3'h0;
			ls_s_r <= 2'h0;
			fs_s_r <= 2'h0;
			pv_s_r <= 2'h0;
			es_s_r <= 2'h0;
			d1_r <= 12'h000;
			d2_r <= 12'h000;
		end else begin
			pclk_s_r <= {pclk_s_r[1:0], vid.pclk};
			ls_s_r <= {ls_s_r[0], vid.line_sync};
			fs_s_r <= {fs_s_r[0], vid.frame_sync};
			pv_s_r <= {pv_s_r[0], vid.pix_valid};
			es_s_r <= {es_s_r[0], vid.ext_sync};
			d1_r <= vid.pix_data;
			d2_r <= d1_r;
		end
	end
	assign take = pv_s_r[1] &&
		(slave_timing || (pclk_s_r[1] && !pclk_s_r[2]));

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pix_word <= 12'h000;
			pix_strobe <= 1'b0;
			line_active <= 1'b0;
			frame_active <= 1'b0;
			shutter_sync <= 1'b0;
		end else begin
			pix_strobe <= take;
			if (take)
				pix_word <= d2_r;
			line_active <= ls_s_r[1];
			frame_active <= fs_s_r[1];
			shutter_sync <= es_s_r[1];
		end
	end
endmodule

// *** test/svpt_assertions.sv ***
// Pin timing checks on the sensor video link
`timescale 1ns/100ps
module svpt_assertions (
	input wire logic clock,
	input wire logic rstn,
	input wire logic pclk,
	input wire logic line_sync,
	input wire logic pix_valid,
	input wire logic ext_sync,
	input wire logic row_trig,
	input wire logic frame_trig,
	input wire logic snap_trig
);
	logic [9:0] gap_r;
	logic [2:0] idle_r;
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	// Cycles since the last row trigger rise
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			gap_r <= 10'h3FF;
		else if ($rose(row_trig))
			gap_r <= 10'h000;
		else if (gap_r != 10'h3FF)
			gap_r <= gap_r + 10'h001;
	end
	// Saturates while pixel clock stands still low
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			idle_r <= 3'h0;
		else if (pclk)
			idle_r <= 3'h0;
		else if (idle_r != 3'h7)
			idle_r <= idle_r + 3'h1;
	end
	sequence s_row_start;
		$rose(row_trig);
	endsequence
	sequence s_first_pix;
		!pix_valid ##1 pix_valid;
	endsequence
	property p_row_width;
		s_row_start |=> row_trig;
	endproperty
	property p_frame_width;
		$rose(frame_trig) |=> frame_trig;
	endproperty
	property p_snap_width;
		$rose(snap_trig) |=> snap_trig;
	endproperty
	property p_first_pix;
		s_row_start |-> ##123 s_first_pix;
	endproperty
	property p_row_gap;
		s_row_start |-> gap_r >= 10'h30B;
	endproperty
	property p_slave_line;
		$rose(pix_valid) && idle_r == 3'h7 |-> line_sync;
	endproperty
	property p_integ_quiet;
		ext_sync |-> !pix_valid;
	endproperty
	property p_delay_first;
		$rose(snap_trig) |-> !ext_sync [*8];
	endproperty
	a_row_width: assert property (p_row_width)
		else $error("row trigger too short");
	a_frame_width: assert property (p_frame_width)
		else $error("frame trigger too short");
	a_snap_width: assert property (p_snap_width)
		else $error("snapshot trigger too short");
	a_first_pix: assert property (p_first_pix)
		else $error("first slave pixel not at 124 cycles");
	a_row_gap: assert property (p_row_gap)
		else $error("row triggers too close");
	a_slave_line: assert property (p_slave_line)
		else $error("slave line sync missing with pixels");
	a_integ_quiet: assert property (p_integ_quiet)
		else $error("pixels during integration");
	a_delay_first: assert property (p_delay_first)
		else $error("shutter sync without delay phase");
endmodule

// *** test/testbench.sv ***
// Self-checking bench joining the sensor and processor ends
`timescale 1ns/100ps
module testbench;
	logic clock, rstn, level_mode, pix_in_black, reg_we, slave_timing;
	logic send_row, send_frame, send_snap, snap_busy, row_ready;
	logic frame_late, pix_strobe;
	svpt_pkg::svpt_mode_t mode;
	logic [7:0] line_sync_lead_adjust, reg_addr, reg_wdata, reg_rdata;
	logic [7:0] offset_voltage_code;
	logic [11:0] frame_length_lines, pix_in, black_level, pix_word;
	logic [11:0] defect_threshold_a, defect_threshold_b;
	int error_cnt = 0;
	int checks = 0;
	int cyc = 0;
	svpt_if vid();
	svpt_sensor svpt_sensor_i (.clock(clock), .rstn(rstn), .vid(vid),
		.mode(mode), .level_mode(level_mode),
		.line_sync_lead_adjust(line_sync_lead_adjust),
		.frame_length_lines(frame_length_lines), .pix_in(pix_in),
		.pix_in_black(pix_in_black), .reg_we(reg_we), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.offset_voltage_code(offset_voltage_code),
		.defect_threshold_a(defect_threshold_a),
		.defect_threshold_b(defect_threshold_b),
		.black_level(black_level), .snap_busy(snap_busy));
	svpt_processor svpt_processor_i (.clock(clock), .rstn(rstn), .vid(vid),
		.slave_timing(slave_timing), .send_row(send_row),
		.send_frame(send_frame), .send_snap(send_snap),
		.row_ready(row_ready), .frame_late(frame_late), .pix_word(pix_word),
		.pix_strobe(pix_strobe), .line_active(), .frame_active(),
		.shutter_sync());
	svpt_assertions svpt_assertions_i (.clock(clock), .rstn(rstn),
		.pclk(vid.pclk), .line_sync(vid.line_sync),
		.pix_valid(vid.pix_valid), .ext_sync(vid.ext_sync),
		.row_trig(vid.row_trig), .frame_trig(vid.frame_trig),
		.snap_trig(vid.snap_trig));
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_we = 1'b1;
		tick(1);
		reg_we = 1'b0;
		tick(1);
	endtask
	task automatic t_regs();
		logic [7:0] val [6];
		val = '{8'hA5, 8'h3C, 8'h81, 8'h7E, 8'hC3, 8'h5B};
		for (int i = 0; i < 6; i++) begin
			reg_addr = 8'h25 + 8'(i);
			tick(2);
			check(24'(reg_rdata), 24'h0);
			reg_wr(8'h25 + 8'(i), val[i]);
		end
		reg_wr(8'h30, 8'hFF);
		for (int i = 0; i < 6; i++) begin
			reg_addr = 8'h25 + 8'(i);
			tick(2);
			check(24'(reg_rdata), 24'(val[i] & ((i == 3 || i == 5) ? 8'hF0 : 8'hFF)));
		end
		check(24'(offset_voltage_code), 24'hA5);
		check(24'(defect_threshold_a), 24'h817);
		check(24'(defect_threshold_b), 24'hC35);
		$display("register test done");
	endtask
	task automatic t_black();
		reg_wr(8'h26, 8'h80);
		pix_in = 12'h800;
		pix_in_black = 1'b1;
		tick(2);
		pix_in_black = 1'b0;
		tick(2);
		check(24'(black_level), 24'h600);
		$display("black level test done");
	endtask
	function automatic logic sig(input logic fs);
		return fs ? vid.frame_sync : vid.line_sync;
	endfunction
	// Counts pixel clock rises in one high and one low span
	task automatic measure(input logic fs, output int lo, hi, fp);
		lo = 0;
		hi = 0;
		fp = 0;
		while (sig(fs) !== 1'b0) @(posedge vid.pclk);
		while (sig(fs) !== 1'b1) @(posedge vid.pclk);
		while (sig(fs) === 1'b1) begin
			hi++;
			if (vid.pix_valid === 1'b1 && fp == 0)
				fp = hi;
			@(posedge vid.pclk);
		end
		while (sig(fs) === 1'b0) begin
			lo++;
			@(posedge vid.pclk);
		end
	endtask
	task automatic t_master(input logic lvl, input logic [7:0] adj);
		int lo, hi, fp;
		mode = svpt_pkg::mode_master;
		level_mode = lvl;
		line_sync_lead_adjust = adj;
		measure(1'b0, lo, hi, fp);
		check(24'(hi), lvl ? 24'h298 - 24'(adj) : 24'h2FC);
		check(24'(lo), lvl ? 24'h74 - 24'(adj) : 24'h10);
		check(24'(fp), 24'(adj) + 24'h2);
		measure(1'b1, lo, hi, fp);
		check(24'(lo), lvl ? 24'h74 : 24'h10);
		check(24'(hi), lvl ? 24'h298 - 24'(2 * adj) : 24'h10);
		$display("master test done");
	endtask
	task automatic pulse_row();
		send_row = 1'b1;
		tick(1);
		send_row = 1'b0;
		tick(1);
	endtask
	task automatic pulse_frame(input logic late);
		send_frame = 1'b1;
		tick(1);
		send_frame = 1'b0;
		tick(2);
		check(24'(frame_late), 24'(late));
	endtask
	task automatic t_slave();
		int n;
		mode = svpt_pkg::mode_slave;
		slave_timing = 1'b1;
		pix_in = 12'hABC;
		tick(4);
		pulse_row();
		check(24'(row_ready), 24'h0);
		tick(20);
		pulse_frame(1'b0);
		n = 0;
		while (vid.pix_valid !== 1'b1) tick(1);
		while (vid.pix_valid === 1'b1) begin
			n++;
			tick(1);
		end
		check(24'(n), 24'h280);
		check(24'(pix_word), 24'hABC);
		pulse_row();
		while (row_ready !== 1'b1) tick(1);
		pulse_row();
		tick(200);
		pulse_frame(1'b1);
		$display("slave test done");
	endtask
	task automatic t_snap();
		int d;
		mode = svpt_pkg::mode_snapshot;
		level_mode = 1'b0;
		slave_timing = 1'b0;
		tick(2);
		send_snap = 1'b1;
		tick(1);
		send_snap = 1'b0;
		d = 0;
		while (vid.ext_sync !== 1'b1) begin
			d++;
			tick(1);
		end
		check(24'((d + 50) / 100), 24'h4E);
		d = 0;
		while (vid.ext_sync === 1'b1) begin
			d++;
			tick(1);
		end
		check(24'((d + 50) / 100), 24'h4E);
		while (snap_busy === 1'b1 && vid.pix_valid !== 1'b1) tick(1);
		check(24'(vid.pix_valid), 24'h1);
		while (snap_busy === 1'b1) tick(1);
		$display("snapshot test done");
	endtask
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	initial begin
		forever begin
			@(posedge clock);
			cyc++;
			if (cyc == 95000) begin
				error_cnt++;
				end_of_test();
			end
		end
	end
	initial begin
		rstn = 1'b0;
		mode = svpt_pkg::mode_master;
		{level_mode, pix_in_black, reg_we, slave_timing} = 4'h0;
		{send_row, send_frame, send_snap} = 3'h0;
		line_sync_lead_adjust = 8'h00;
		{reg_addr, reg_wdata} = 16'h0000;
		frame_length_lines = 12'h001;
		pix_in = 12'h000;
		tick(10);
		rstn = 1'b1;
		tick(1);
		t_regs();
		t_black();
		t_master(1'b0, 8'h04);
		t_master(1'b1, 8'h04);
		t_slave();
		t_snap();
		end_of_test();
	end
endmodule
